/* File: rtl/panel_pkg.sv */
// shared constants and carrier types for the front panel keypad and indicator block
package panel_pkg;

  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned DEBOUNCE_MS   = 10;
  localparam int unsigned LONG_PRESS_S  = 3;
  localparam int unsigned COM_HOLD_MS   = 50;
  localparam int unsigned DEBOUNCE_CYC  = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned LONG_PRESS_CYC = CLK_HZ * LONG_PRESS_S;
  localparam int unsigned COM_HOLD_CYC  = (CLK_HZ / 1000) * COM_HOLD_MS;
  localparam int          CNT_W         = 29;

  localparam int KEY_N    = 7;
  localparam int MATRIX_N = 16;
  localparam int APP_N    = 3;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;

  // key indices within the raw key vector
  localparam int KEY_BACK    = 0;
  localparam int KEY_INFO    = 1;
  localparam int KEY_CONFIRM = 2;
  localparam int KEY_UP      = 3;
  localparam int KEY_DOWN    = 4;
  localparam int KEY_LEFT    = 5;
  localparam int KEY_RIGHT   = 6;

  // positions of the other pins in the synchroniser vector
  localparam int PIN_AUX   = 7;
  localparam int PIN_FAULT = 8;
  localparam int PIN_COM   = 9;
  localparam int PIN_DI    = 10;
  localparam int PIN_N     = 11;

  localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ALARM_MAP = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TRIP_MAP  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RELEASE   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h18;

  localparam int CTRL_EDIT        = 0;
  localparam int CTRL_ALARM_LATCH = 1;
  localparam int CTRL_TRIP_LATCH  = 2;
  localparam int CTRL_APP_LATCH   = 3;
  localparam int CTRL_W           = 6;
  localparam int REL_BIT          = 0;
  localparam int STAT_LONG        = 8;

  localparam int IRQ_KEY   = 0;
  localparam int IRQ_LONG  = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_ALARM = 3;
  localparam int IRQ_TRIP  = 4;
  localparam int IRQ_N     = 5;

  localparam logic [CTRL_W-1:0]   CTRL_RST = 6'h00;
  localparam logic [MATRIX_N-1:0] MAP_RST  = 16'h0000;
  localparam logic [IRQ_N-1:0]    IRQ_RST  = 5'h00;

  typedef enum logic [2:0] {
    BK_IDLE = 3'b001,
    BK_HELD = 3'b010,
    BK_LONG = 3'b100
  } back_state_t;

  typedef struct packed {
    logic app_c;
    logic app_b;
    logic app_a;
    logic trip;
    logic alarm;
    logic com;
    logic error;
    logic power;
  } led_t;

  typedef struct packed {
    logic prev_menu;
    logic top_menu;
    logic info;
    logic confirm;
    logic sel_up;
    logic sel_down;
    logic val_inc;
    logic val_dec;
    logic menu_prev;
    logic menu_next;
    logic digit_left;
    logic digit_right;
  } action_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

endpackage

/* File: rtl/front_panel_indicator_keypad.sv */
// front panel keypad decoder, indicator driver and register port
// Functional notes
// - latched relay or indicator stays on after its source drops, until released
// - short back press steps back; three second hold jumps to main menu top
// - info key requests extra info, password view and contrast access
// - confirm key issues an activate or confirm action
// - up key moves selection up, or increments value while editing
// - down key moves selection down, or decrements value while editing
// - left key steps back in parallel menu, or moves digit while editing
// - right key steps forward in parallel menu, or moves digit while editing
// - eight indicator outputs: power, error, com, alarm, trip, three application
// - power indicator lit while running on auxiliary power
// - error indicator and self-supervision relay share one fault condition
// - internal fault requests reboot; error stays lit while fault persists
// - com indicator lit or flashing while the serial bus transfers data
// - alarm indicator is the OR of all matrix signals mapped to alarm
// - trip indicator is the OR of all matrix signals mapped to trip
// - alarm indicator follows its source if connected, holds if latched
// - trip indicator follows its source if connected, holds if latched
// - latched outputs also released by remote command or digital input
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module front_panel_indicator_keypad #(
  parameter int unsigned DEBOUNCE_CYCLES   = panel_pkg::DEBOUNCE_CYC,
  parameter int unsigned LONG_PRESS_CYCLES = panel_pkg::LONG_PRESS_CYC,
  parameter int unsigned COM_HOLD_CYCLES   = panel_pkg::COM_HOLD_CYC
) (
  input  wire logic                             clk_sys,
  input  wire logic                             rst_n,
  input  wire logic [panel_pkg::KEY_N-1:0]      key_raw,
  input  wire logic                             aux_power_pin,
  input  wire logic                             fault_pin,
  input  wire logic                             serial_busy_pin,
  input  wire logic                             release_di_pin,
  input  wire logic                             remote_release,
  input  wire logic [panel_pkg::MATRIX_N-1:0]   matrix_sig,
  input  wire logic [panel_pkg::APP_N-1:0]      app_ind,
  input  wire panel_pkg::reg_req_t              reg_req,
  output      logic [panel_pkg::DATA_W-1:0]     rd_data,
  output      panel_pkg::led_t                  leds,
  output      logic                             alarm_matrix_output,
  output      logic                             trip_matrix_output,
  output      logic                             selfsup_relay,
  output      logic                             reboot_req,
  output      panel_pkg::action_t               action,
  output      logic                             long_press,
  output      logic                             irq
);
  import panel_pkg::*;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  function automatic logic any_mapped(input logic [MATRIX_N-1:0] sig,
                                      input logic [MATRIX_N-1:0] map);
    any_mapped = |(sig & map);
  endfunction

  logic [PIN_N-1:0]    sync1;
  logic [PIN_N-1:0]    sync2;
  logic [KEY_N-1:0]    key_db;
  logic [KEY_N-1:0]    key_prev;
  logic [CNT_W-1:0]    db_cnt [KEY_N];
  logic [KEY_N-1:0]    press;
  back_state_t         bk_state;
  back_state_t         next_bk_state;
  logic [CNT_W-1:0]    hold_cnt;
  logic [CNT_W-1:0]    next_hold_cnt;
  logic                back_short;
  logic                back_long;
  logic [CTRL_W-1:0]   ctrl;
  logic [MATRIX_N-1:0] alarm_map;
  logic [MATRIX_N-1:0] trip_map;
  logic [IRQ_N-1:0]    irq_stat;
  logic [IRQ_N-1:0]    irq_mask;
  logic [IRQ_N-1:0]    irq_event;
  logic                di_prev;
  logic                fault_prev;
  logic                release_req;
  logic                alarm_src;
  logic                trip_src;
  logic [4:0]          ind_src;
  logic [4:0]          ind_mode;
  logic [4:0]          ind_hold;
  logic [4:0]          ind_out;
  logic [CNT_W-1:0]    com_cnt;
  logic                edit;
  logic                wr_hit_release;

  assign edit = ctrl[CTRL_EDIT];

  // two flops on every key and status pin before anything looks at it; remote release, matrix and app inputs are used directly
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {release_di_pin, serial_busy_pin, fault_pin, aux_power_pin, key_raw};
      sync2 <= sync1;
    end
  end

  // a key state changes only after it has disagreed for the whole debounce time
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      key_db <= '0;
      for (int k = 0; k < KEY_N; k++) begin
        db_cnt[k] <= '0;
      end
    end else begin
      for (int k = 0; k < KEY_N; k++) begin
        if (sync2[k] == key_db[k]) begin
          db_cnt[k] <= '0;
        end else if (db_cnt[k] == CNT_W'(DEBOUNCE_CYCLES - 1)) begin
          db_cnt[k] <= '0;
          key_db[k] <= sync2[k];
        end else begin
          db_cnt[k] <= db_cnt[k] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      key_prev <= '0;
    end else begin
      key_prev <= key_db;
    end
  end

  assign press = key_db & ~key_prev;

  // back key: the short action waits for release so a long hold never steps back first
  always_comb begin
    next_bk_state = bk_state;
    next_hold_cnt = hold_cnt;
    back_short    = 1'b0;
    back_long     = 1'b0;
    unique case (bk_state)
      BK_IDLE: begin
        next_hold_cnt = '0;
        if (press[KEY_BACK]) begin
          next_bk_state = BK_HELD;
        end
      end
      BK_HELD: begin
        if (!key_db[KEY_BACK]) begin
          next_bk_state = BK_IDLE;
          back_short    = 1'b1;
        end else if (hold_cnt == CNT_W'(LONG_PRESS_CYCLES - 1)) begin
          next_bk_state = BK_LONG;
          back_long     = 1'b1;
        end else begin
          next_hold_cnt = hold_cnt + 1'b1;
        end
      end
      BK_LONG: begin
        if (!key_db[KEY_BACK]) begin
          next_bk_state = BK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bk_state <= BK_IDLE;
      hold_cnt <= '0;
    end else begin
      bk_state <= next_bk_state;
      hold_cnt <= next_hold_cnt;
    end
  end

  assign long_press = (bk_state == BK_LONG);

  // edit mode steers the arrow keys between menu moves and value edits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      action <= '0;
    end else begin
      action.prev_menu   <= back_short;
      action.top_menu    <= back_long;
      action.info        <= press[KEY_INFO];
      action.confirm     <= press[KEY_CONFIRM];
      action.sel_up      <= press[KEY_UP] & ~edit;
      action.val_inc     <= press[KEY_UP] & edit;
      action.sel_down    <= press[KEY_DOWN] & ~edit;
      action.val_dec     <= press[KEY_DOWN] & edit;
      action.menu_prev   <= press[KEY_LEFT] & ~edit;
      action.digit_left  <= press[KEY_LEFT] & edit;
      action.menu_next   <= press[KEY_RIGHT] & ~edit;
      action.digit_right <= press[KEY_RIGHT] & edit;
    end
  end

  a_long_top_menu: assert property (action.top_menu |-> long_press)
    else $error("top menu action without long press state");
  a_short_no_long: assert property ((bk_state == BK_HELD && !key_db[KEY_BACK])
                                    |=> action.prev_menu && !long_press)
    else $error("back release did not step to previous menu");
  a_edit_up_inc: assert property ((press[KEY_UP] && edit)
                                  |=> action.val_inc && !action.sel_up)
    else $error("up key in edit mode did not increment");
  a_down_select: assert property ((press[KEY_DOWN] && !edit)
                                  |=> action.sel_down && !action.val_dec)
    else $error("down key outside edit did not move selection");
  a_confirm_single: assert property (action.confirm |=> !action.confirm)
    else $error("confirm action longer than one cycle");
  a_key_debounce: assert property ($rose(key_db[KEY_INFO])
                                   |-> $past(sync2[KEY_INFO]))
    else $error("key state changed without its input");

  c_long_press: cover property (back_long);
  c_short_back: cover property (action.prev_menu);

  // release sources; a digital input acts on its rising edge only
  assign wr_hit_release = reg_req.wr && (reg_req.addr == OFS_RELEASE) && reg_req.wdata[REL_BIT];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      di_prev <= 1'b0;
    end else begin
      di_prev <= sync2[PIN_DI];
    end
  end

  assign release_req = wr_hit_release | remote_release | (sync2[PIN_DI] & ~di_prev);

  assign alarm_src = any_mapped(matrix_sig, alarm_map);
  assign trip_src  = any_mapped(matrix_sig, trip_map);
  assign ind_src   = {app_ind, trip_src, alarm_src};
  assign ind_mode  = {ctrl[CTRL_APP_LATCH +: APP_N], ctrl[CTRL_TRIP_LATCH],
                      ctrl[CTRL_ALARM_LATCH]};

  // an active source beats a release in the same cycle, so nothing is lost
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ind_hold <= '0;
    end else begin
      ind_hold <= ind_src | (ind_hold & ind_mode & {5{~release_req}});
    end
  end

  assign ind_out = ind_src | (ind_hold & ind_mode);

  // com indicator stretched so that short bursts stay visible
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      com_cnt <= '0;
    end else if (sync2[PIN_COM]) begin
      com_cnt <= CNT_W'(COM_HOLD_CYCLES);
    end else if (com_cnt != '0) begin
      com_cnt <= com_cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      leds                <= '0;
      alarm_matrix_output <= 1'b0;
      trip_matrix_output  <= 1'b0;
      selfsup_relay       <= 1'b0;
    end else begin
      leds.power          <= sync2[PIN_AUX];
      leds.error          <= sync2[PIN_FAULT];
      selfsup_relay       <= sync2[PIN_FAULT];
      leds.com            <= sync2[PIN_COM] | (com_cnt != '0);
      leds.alarm          <= ind_out[0];
      leds.trip           <= ind_out[1];
      {leds.app_c, leds.app_b, leds.app_a} <= ind_out[4:2];
      alarm_matrix_output <= ind_out[0];
      trip_matrix_output  <= ind_out[1];
    end
  end

  // reboot is asked once per fault onset; the led keeps showing a lasting fault
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_prev <= 1'b0;
      reboot_req <= 1'b0;
    end else begin
      fault_prev <= sync2[PIN_FAULT];
      reboot_req <= sync2[PIN_FAULT] & ~fault_prev;
    end
  end

  a_latch_alarm_hold: assert property ((ctrl[CTRL_ALARM_LATCH] && $past(alarm_src)
                                        && !alarm_src && !release_req) |=> leds.alarm)
    else $error("latched alarm dropped without release");
  a_trip_connected: assert property ((!ctrl[CTRL_TRIP_LATCH] && !trip_src)
                                     |=> !leds.trip && !trip_matrix_output)
    else $error("connected trip stayed on after source reset");
  a_alarm_or_map: assert property (alarm_src |=> leds.alarm && alarm_matrix_output)
    else $error("mapped alarm signal did not light alarm");
  a_trip_or_map: assert property (trip_src |=> leds.trip)
    else $error("mapped trip signal did not light trip");
  a_release_clears: assert property ((release_req && !alarm_src) ##1 !alarm_src
                                     |=> !leds.alarm)
    else $error("release did not clear alarm");
  a_error_relay_pair: assert property (leds.error == selfsup_relay)
    else $error("error led and self-supervision relay differ");
  a_reboot_onset: assert property (reboot_req |-> leds.error && !$past(leds.error))
    else $error("reboot request without fault onset");
  a_power_follow: assert property (sync2[PIN_AUX] |=> leds.power)
    else $error("power led off while on auxiliary power");
  a_com_lit: assert property (sync2[PIN_COM] |=> leds.com [*2])
    else $error("com led not lit during bus activity");

  c_latched_release: cover property (ctrl[CTRL_ALARM_LATCH] && ind_hold[0] && release_req);
  c_reboot: cover property (reboot_req);

  // register writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl      <= CTRL_RST;
      alarm_map <= MAP_RST;
      trip_map  <= MAP_RST;
      irq_mask  <= IRQ_RST;
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        OFS_CTRL:      ctrl      <= reg_req.wdata[CTRL_W-1:0];
        OFS_ALARM_MAP: alarm_map <= reg_req.wdata[MATRIX_N-1:0];
        OFS_TRIP_MAP:  trip_map  <= reg_req.wdata[MATRIX_N-1:0];
        OFS_IRQ_MASK:  irq_mask  <= reg_req.wdata[IRQ_N-1:0];
        default: begin
        end
      endcase
    end
  end

  assign irq_event[IRQ_KEY]   = |press;
  assign irq_event[IRQ_LONG]  = back_long;
  assign irq_event[IRQ_FAULT] = sync2[PIN_FAULT] & ~fault_prev;
  assign irq_event[IRQ_ALARM] = ind_out[0] & ~leds.alarm;
  assign irq_event[IRQ_TRIP]  = ind_out[1] & ~leds.trip;

  // write-one-to-clear; a new event in the clearing cycle keeps its bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= IRQ_RST;
    end else if (reg_req.wr && reg_req.addr == OFS_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~reg_req.wdata[IRQ_N-1:0]) | irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        OFS_CTRL:      rd_data <= DATA_W'(ctrl);
        OFS_ALARM_MAP: rd_data <= DATA_W'(alarm_map);
        OFS_TRIP_MAP:  rd_data <= DATA_W'(trip_map);
        OFS_STATUS:    rd_data <= DATA_W'({long_press, leds});
        OFS_IRQ_STAT:  rd_data <= DATA_W'(irq_stat);
        OFS_IRQ_MASK:  rd_data <= DATA_W'(irq_mask);
        default:       rd_data <= '0;
      endcase
    end else begin
      rd_data <= '0;
    end
  end

  c_irq_raised: cover property (irq);

endmodule // front_panel_indicator_keypad

/* File: dv/panel_operator.sv */
// behavioural operator model pressing panel keys with contact bounce
`timescale 1ns/10ps
module panel_operator (
  input  wire logic                        clk_sys,
  output      logic [panel_pkg::KEY_N-1:0] key_raw
);
  import panel_pkg::*;

  // released keys read low through the pull-down, never the last value
  initial key_raw = '0;

  // bounce pulses are one cycle each, well under the debounce window
  task automatic press(input int k, input int hold, input bit bounce);
    if (bounce) begin
      repeat (2) begin
        @(posedge clk_sys);
        key_raw[k] <= 1'b1;
        @(posedge clk_sys);
        key_raw[k] <= 1'b0;
      end
    end
    @(posedge clk_sys);
    key_raw[k] <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    key_raw[k] <= 1'b0;
  endtask
endmodule // panel_operator

/* File: dv/front_panel_indicator_keypad_tb_top.sv */
// self-checking testbench of the front panel keypad and indicator block
`timescale 1ns/10ps
module front_panel_indicator_keypad_tb_top;
  import panel_pkg::*;

  logic                clk_sys;
  logic                rst_n;
  logic [KEY_N-1:0]    key_raw;
  logic                aux_power_pin;
  logic                fault_pin;
  logic                serial_busy_pin;
  logic                release_di_pin;
  logic                remote_release;
  logic [MATRIX_N-1:0] matrix_sig;
  logic [APP_N-1:0]    app_ind;
  reg_req_t            req;
  logic [DATA_W-1:0]   rd_data;
  led_t                leds;
  logic                alarm_matrix_output;
  logic                trip_matrix_output;
  logic                selfsup_relay;
  logic                reboot_req;
  action_t             action;
  logic                long_press;
  logic                irq;
  int                  n_fail;
  int                  comparisons;
  logic [31:0]         act_or;
  int                  act_n;
  int                  lp_seen;
  int                  rb_n;
  int                  kt[6] = '{KEY_INFO, KEY_CONFIRM, KEY_UP, KEY_DOWN, KEY_LEFT, KEY_RIGHT};
  int                  b0[6] = '{9, 8, 7, 6, 3, 2};
  int                  b1[6] = '{9, 8, 5, 4, 1, 0};
  logic [7:0]          ofs[7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h40};

  front_panel_indicator_keypad #(
    .DEBOUNCE_CYCLES   (4),
    .LONG_PRESS_CYCLES (20),
    .COM_HOLD_CYCLES   (5)
  ) front_panel_indicator_keypad_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .key_raw(key_raw), .aux_power_pin(aux_power_pin),
    .fault_pin(fault_pin), .serial_busy_pin(serial_busy_pin), .release_di_pin(release_di_pin),
    .remote_release(remote_release), .matrix_sig(matrix_sig), .app_ind(app_ind),
    .reg_req(req), .rd_data(rd_data), .leds(leds), .alarm_matrix_output(alarm_matrix_output),
    .trip_matrix_output(trip_matrix_output), .selfsup_relay(selfsup_relay),
    .reboot_req(reboot_req), .action(action), .long_press(long_press), .irq(irq)
  );

  panel_operator panel_operator_i (.clk_sys(clk_sys), .key_raw(key_raw));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask

  // read data is only valid in the single cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    check("rd_data", rd_data, exp);
  endtask

  task automatic watch(input int n);
    act_or = '0;
    act_n = 0;
    lp_seen = 0;
    rb_n = 0;
    repeat (n) begin
      step(1);
      act_or |= 32'(action);
      if (action !== '0) act_n++;
      if (long_press === 1'b1) lp_seen = 1;
      if (reboot_req === 1'b1) rb_n++;
    end
  endtask

  task automatic drive_mx(input logic [MATRIX_N-1:0] v);
    @(posedge clk_sys);
    matrix_sig <= v;
    step(1);
  endtask

  function automatic logic [3:0] outs();
    return {alarm_matrix_output, trip_matrix_output, leds.alarm, leds.trip};
  endfunction

  task automatic t_keys();
    for (int e = 0; e < 2; e++) begin
      wr(OFS_CTRL, 32'(e));
      for (int i = 0; i < 6; i++) begin
        fork
          panel_operator_i.press(kt[i], 12, 1'b1);
          watch(40);
        join
        check("action", act_or, 32'h1 << (e ? b1[i] : b0[i]));
        check("action pulses", act_n, 1);
      end
    end
    wr(OFS_CTRL, 32'h0000_0000);
  endtask

  task automatic t_back();
    fork
      panel_operator_i.press(KEY_BACK, 10, 1'b1);
      watch(40);
    join
    check("short back", {act_or[15:0], 8'(act_n), 8'(lp_seen)}, 32'h0800_0100);
    fork
      panel_operator_i.press(KEY_BACK, 40, 1'b0);
      watch(70);
    join
    check("long back", {act_or[15:0], 8'(act_n), 8'(lp_seen)}, 32'h0400_0101);
    check("long_press", long_press, 1'b0);
    fork
      panel_operator_i.press(KEY_INFO, 1, 1'b0);
      watch(20);
    join
    check("glitch pulses", act_n, 0);
  endtask

  task automatic t_irq();
    wr(OFS_IRQ_STAT, 32'h0000_001F);
    rd(OFS_IRQ_STAT, 32'h0000_0000);
    wr(OFS_ALARM_MAP, 32'h0000_0001);
    drive_mx(16'h0001);
    drive_mx(16'h0000);
    rd(OFS_IRQ_STAT, 32'h0000_0008);
    check("irq masked", irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h0000_0008);
    step(1);
    check("irq", irq, 1'b1);
    wr(OFS_IRQ_STAT, 32'h0000_0008);
    step(1);
    check("irq cleared", irq, 1'b0);
    rd(OFS_IRQ_STAT, 32'h0000_0000);
  endtask

  task automatic rel_pulse();
    @(posedge clk_sys);
    remote_release <= 1'b1;
    @(posedge clk_sys);
    remote_release <= 1'b0;
    step(1);
  endtask

  // each pass latches both outputs, then frees them through one release path
  task automatic t_latch();
    wr(OFS_ALARM_MAP, 32'h0000_0003);
    wr(OFS_TRIP_MAP, 32'h0000_8000);
    drive_mx(16'h0002);
    check("alarm or", outs(), 4'hA);
    drive_mx(16'h8000);
    check("connected", outs(), 4'h5);
    drive_mx(16'h0000);
    check("connected off", outs(), 4'h0);
    wr(OFS_CTRL, 32'h0000_0006);
    for (int p = 0; p < 3; p++) begin
      drive_mx(16'h8001);
      rel_pulse();
      check("source wins", outs(), 4'hF);
      drive_mx(16'h0000);
      step(5);
      check("latched", outs(), 4'hF);
      if (p == 0) rel_pulse();
      if (p == 1) wr(OFS_RELEASE, 32'h0000_0001);
      if (p == 2) begin
        @(posedge clk_sys);
        release_di_pin <= 1'b1;
      end
      step(6);
      check("released", outs(), 4'h0);
      @(posedge clk_sys);
      release_di_pin <= 1'b0;
    end
    wr(OFS_CTRL, 32'h0000_0000);
  endtask

  task automatic t_status();
    @(posedge clk_sys);
    aux_power_pin <= 1'b1;
    step(5);
    check("power", leds.power, 1'b1);
    rd(OFS_STATUS, 32'h0000_0001);
    wr(OFS_STATUS, 32'h0000_00FF);
    rd(OFS_STATUS, 32'h0000_0001);
    @(posedge clk_sys);
    app_ind <= 3'h5;
    step(5);
    check("app leds", {leds.app_c, leds.app_b, leds.app_a}, 3'h5);
  endtask

  task automatic t_fault_com();
    fork
      begin
        @(posedge clk_sys);
        fault_pin <= 1'b1;
      end
      watch(10);
    join
    check("reboot pulses", rb_n, 1);
    check("error relay", {leds.error, selfsup_relay}, 2'h3);
    step(20);
    check("error held", {leds.error, selfsup_relay}, 2'h3);
    @(posedge clk_sys);
    fault_pin <= 1'b0;
    step(5);
    check("error off", {leds.error, selfsup_relay}, 2'h0);
    @(posedge clk_sys);
    serial_busy_pin <= 1'b1;
    step(5);
    check("com on", leds.com, 1'b1);
    @(posedge clk_sys);
    serial_busy_pin <= 1'b0;
    step(3);
    check("com stretch", leds.com, 1'b1);
    step(20);
    check("com off", leds.com, 1'b0);
  endtask

  initial begin
    n_fail = 0;
    comparisons = 0;
    rst_n = 1'b0;
    req = '0;
    {aux_power_pin, fault_pin, serial_busy_pin, release_di_pin, remote_release} = '0;
    matrix_sig = '0;
    app_ind = '0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    step(1);
    check("reset outs", {leds, action, long_press, irq, rd_data[7:0]}, 32'h0000_0000);
    for (int i = 0; i < 7; i++) rd(ofs[i], 32'h0000_0000);
    t_status();
    t_keys();
    t_back();
    t_irq();
    t_latch();
    t_fault_com();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    complete_run();
  end
endmodule // front_panel_indicator_keypad_tb_top
